// File: rtl/acc_pkg.sv
// constants for the converter clocking and conversion-rate block
// assumes a 100 MHz system clock; serial pins come from outside this domain
package acc_pkg;

  // ==========================================================
  // clock and time base
  localparam int SYS_CLK_HZ        = 100_000_000;
  localparam int SYS_CLK_PERIOD_NS = 10;

  // ==========================================================
  // conversion timing
  localparam int OSC_NOM_HZ       = 64_000;
  localparam int OSC_DIV          = SYS_CLK_HZ / OSC_NOM_HZ;
  localparam int WORD_DIV         = 612;
  localparam int EARLY_RISE_TICKS = 17;
  localparam int SETTLE_WORDS     = 4;
  localparam int WORD_BITS        = 24;

  // ==========================================================
  // sleep and wake timing
  localparam int SLEEP_ENTRY_MIN_US = 200;
  localparam int SLEEP_ENTRY_MAX_US = 2000;
  localparam int SLEEP_CYCLES       = SLEEP_ENTRY_MIN_US * 1000 / SYS_CLK_PERIOD_NS;
  localparam int WAKE_HOLD_NS       = 10_000;
  localparam int WAKE_CYCLES        = WAKE_HOLD_NS / SYS_CLK_PERIOD_NS;

  // ==========================================================
  // read port state machine
  typedef enum logic [2:0] {
    ACC_RD_IDLE  = 3'b001,
    ACC_RD_ARMED = 3'b010,
    ACC_RD_SHIFT = 3'b100
  } acc_rd_state_t;

endpackage : acc_pkg

// File: rtl/acc_rate_gen.sv
// master clock tick and output word rate generator
// assumes serial_clk_rise is a one-cycle pulse from synchronised logic
`timescale 1ns/1ps

module acc_rate_gen #(
  parameter bit INT_OSC = 1'b0
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic run,
  input  wire logic serial_clk_rise,
  output logic      word_strobe,
  output logic      early_rise
);

  logic [10:0] osc_cnt_ff;
  logic [9:0]  word_cnt_ff;
  logic        master_tick;

  // ==========================================================
  // master clock source
  // nominal rate only; part-to-part spread is not modelled
  assign master_tick = INT_OSC ? (osc_cnt_ff == 11'(acc_pkg::OSC_DIV - 1)) // [RL3]
                               : serial_clk_rise;                          // [RL1]

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      osc_cnt_ff <= 11'h000;
    else if (!run || !INT_OSC || master_tick)
      osc_cnt_ff <= 11'h000;
    else
      osc_cnt_ff <= osc_cnt_ff + 11'h001;
  end

  // ==========================================================
  // word rate divider, runs freely with no start command
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      word_cnt_ff <= 10'h000;
    else if (!run)
      word_cnt_ff <= 10'h000;
    else if (master_tick)
    begin
      if (word_cnt_ff == 10'(acc_pkg::WORD_DIV - 1))
        word_cnt_ff <= 10'h000;                                    // [RL2] [RL4] [RL6]
      else
        word_cnt_ff <= word_cnt_ff + 10'h001;
    end
  end

  assign word_strobe = run && master_tick && (word_cnt_ff == 10'(acc_pkg::WORD_DIV - 1));
  assign early_rise  = word_cnt_ff >= 10'(acc_pkg::WORD_DIV - acc_pkg::EARLY_RISE_TICKS);

endmodule : acc_rate_gen

// File: rtl/acc_top.sv
// converter clocking, sleep control and serial word read port
// assumes serial_clk and chip_select_n are pins from the host, asynchronous to sys_clk;
// sample_data and flags come from the filter on sys_clk
//
// What this block does
// [RL1] - external variant clocks conversions from serial clock
// [RL2] - external variant: one word per 612 clocks
// [RL3] - internal variant uses 64 kHz on-chip oscillator
// [RL4] - internal variant: oscillator divided by 612
// [RL5] - internal variant: serial clock only reads/sleeps
// [RL6] - conversions run continuously without start command
// [RL7] - serial clock asynchronous, crossed safely, up to 2 MHz
// [RL8] - host reads at converter clock in external variant
// [RL9] - host keeps clock under 130/200 kHz, 22ns jitter
// [RL10] - no on-chip offset or gain calibration
// [RL11] - serial clock held high long enters sleep
// [RL12] - serial clock low 10 us wakes device
// [RL13] - data out low signals ready; hi-Z when deselected
// [RL14] - host reads 24 bits on rising edges
`timescale 1ns/1ps

module acc_top #(
  parameter bit INT_OSC      = 1'b0,
  parameter bit RES20        = 1'b1,
  parameter int SLEEP_CYCLES = acc_pkg::SLEEP_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        serial_clk,
  input  wire logic        chip_select_n,
  input  wire logic [19:0] sample_data,
  input  wire logic        over_range,
  input  wire logic        osc_detect,
  output logic             serial_data_out,
  output logic             serial_data_out_oe,
  output logic             sleep_active,
  output logic             word_ready
);

  logic                  rst_m_ff;
  logic                  rst_n;
  logic                  sclk_m_ff;
  logic                  sclk_s_ff;
  logic                  sclk_d_ff;
  logic                  cs_m_ff;
  logic                  cs_s_ff;
  logic                  sclk_rise;
  logic                  sclk_fall;
  logic [20:0]           hi_cnt_ff;
  logic [10:0]           lo_cnt_ff;
  logic                  sleep_ff;
  logic [2:0]            settle_ff;
  logic                  word_strobe;
  logic                  early_rise;
  logic                  avail_ff;
  logic [23:0]           word_ff;
  logic [23:0]           sh_ff;
  logic                  skip_ff;
  logic [4:0]            rise_cnt_ff;
  logic                  sdo_ff;
  logic                  oe_ff;
  acc_pkg::acc_rd_state_t state_ff;

  // ==========================================================
  // reset release and pin synchronisers
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_m_ff <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_m_ff <= 1'b1;
      rst_n    <= rst_m_ff;
    end
  end

  // cs idles high so the output stays released through reset
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclk_m_ff <= 1'b0;
      sclk_s_ff <= 1'b0;
      sclk_d_ff <= 1'b0;
      cs_m_ff   <= 1'b1;
      cs_s_ff   <= 1'b1;
    end
    else
    begin
      sclk_m_ff <= serial_clk;                                       // [RL7]
      sclk_s_ff <= sclk_m_ff;
      sclk_d_ff <= sclk_s_ff;
      cs_m_ff   <= chip_select_n;
      cs_s_ff   <= cs_m_ff;
    end
  end

  // edges are only seen on the second stage, so 2 MHz leaves 25 samples per phase
  assign sclk_rise = sclk_s_ff && !sclk_d_ff;
  assign sclk_fall = !sclk_s_ff && sclk_d_ff;

  // ==========================================================
  // sleep entry and wake
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hi_cnt_ff <= 21'h000000;
      lo_cnt_ff <= 11'h000;
    end
    else
    begin
      hi_cnt_ff <= (sclk_s_ff && hi_cnt_ff != 21'(SLEEP_CYCLES - 1)) ? hi_cnt_ff + 21'h000001
                 : (sclk_s_ff ? hi_cnt_ff : 21'h000000);
      lo_cnt_ff <= (!sclk_s_ff && lo_cnt_ff != 11'(acc_pkg::WAKE_CYCLES - 1)) ? lo_cnt_ff + 11'h001
                 : (!sclk_s_ff ? lo_cnt_ff : 11'h000);
    end
  end

  // threshold sits at the low end of the entry window, so slow reads must keep bursting
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      sleep_ff <= 1'b0;
    else if (!sleep_ff && hi_cnt_ff == 21'(SLEEP_CYCLES - 1))
      sleep_ff <= 1'b1;                                              // [RL11]
    else if (sleep_ff && lo_cnt_ff == 11'(acc_pkg::WAKE_CYCLES - 1))
      sleep_ff <= 1'b0;                                              // [RL12]
  end

  // ==========================================================
  // word rate and filter settling
  acc_rate_gen #(
    .INT_OSC (INT_OSC)
  ) u_rate (
    .sys_clk         (sys_clk),
    .rst_n           (rst_n),
    .run             (!sleep_ff),
    .serial_clk_rise (INT_OSC ? 1'b0 : sclk_rise),                   // [RL5]
    .word_strobe     (word_strobe),
    .early_rise      (early_rise)
  );

  // the filter needs four words after reset or wake before output is valid
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      settle_ff <= 3'h0;
    else if (sleep_ff)
      settle_ff <= 3'h0;
    else if (word_strobe && settle_ff != 3'(acc_pkg::SETTLE_WORDS))
      settle_ff <= settle_ff + 3'h1;
  end

  // ==========================================================
  // output word capture; words arriving during a read are dropped
  // raw filter result is passed on untouched except that RES20 off clears its top 4 bits; any correction is left to the host  [RL10]
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      word_ff <= 24'h000000;
    else if (word_strobe && state_ff == acc_pkg::ACC_RD_IDLE)
      word_ff <= {1'b0, over_range, osc_detect, 1'b0,
                  RES20 ? sample_data : {4'h0, sample_data[15:0]}};
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      avail_ff <= 1'b0;
    else if (word_strobe && state_ff == acc_pkg::ACC_RD_IDLE)
      avail_ff <= settle_ff == 3'(acc_pkg::SETTLE_WORDS);
    else if (state_ff != acc_pkg::ACC_RD_IDLE && (cs_s_ff || sleep_ff))
      avail_ff <= 1'b0;
    else if (state_ff == acc_pkg::ACC_RD_SHIFT && sclk_rise
             && rise_cnt_ff == 5'(acc_pkg::WORD_BITS - 1))
      avail_ff <= 1'b0;
    else if (INT_OSC && state_ff == acc_pkg::ACC_RD_ARMED && early_rise)
      avail_ff <= 1'b0;
  end

  // ==========================================================
  // serial read machine
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff    <= acc_pkg::ACC_RD_IDLE;
      sh_ff       <= 24'h000000;
      skip_ff     <= 1'b0;
      rise_cnt_ff <= 5'h00;
      sdo_ff      <= 1'b1;
    end
    else
    begin
      unique case (state_ff)
        acc_pkg::ACC_RD_IDLE:
        begin
          sdo_ff      <= 1'b1;
          rise_cnt_ff <= 5'h00;
          if (avail_ff && !cs_s_ff && !sleep_ff && (INT_OSC || sclk_rise))
          begin
            state_ff <= acc_pkg::ACC_RD_ARMED;
            sh_ff    <= word_ff;
            sdo_ff   <= word_ff[23];                                 // [RL13]
            skip_ff  <= !INT_OSC;
          end
        end
        acc_pkg::ACC_RD_ARMED, acc_pkg::ACC_RD_SHIFT:
        begin
          if (cs_s_ff || sleep_ff)
          begin
            state_ff <= acc_pkg::ACC_RD_IDLE;
            sdo_ff   <= 1'b1;
          end
          else if (INT_OSC && state_ff == acc_pkg::ACC_RD_ARMED && early_rise)
          begin
            state_ff <= acc_pkg::ACC_RD_IDLE;
            sdo_ff   <= 1'b1;
          end
          else if (sclk_fall && skip_ff)
            skip_ff <= 1'b0;                                         // [RL8]
          else if (sclk_fall && state_ff == acc_pkg::ACC_RD_SHIFT)
          begin
            sh_ff  <= {sh_ff[22:0], 1'b0};
            sdo_ff <= sh_ff[22];
          end
          else if (sclk_rise && !skip_ff)
          begin
            if (rise_cnt_ff == 5'(acc_pkg::WORD_BITS - 1))
            begin
              state_ff <= acc_pkg::ACC_RD_IDLE;                      // [RL14]
              sdo_ff   <= 1'b1;
            end
            else
            begin
              state_ff    <= acc_pkg::ACC_RD_SHIFT;
              rise_cnt_ff <= rise_cnt_ff + 5'h01;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      oe_ff <= 1'b0;
    else
      oe_ff <= !cs_s_ff;                                             // [RL13]
  end

  assign serial_data_out    = sdo_ff;
  assign serial_data_out_oe = oe_ff;
  assign sleep_active       = sleep_ff;
  assign word_ready         = avail_ff;

endmodule : acc_top

// File: testbench/acc_host_model.sv
// host model: serial clock source and 24-bit word reader
// assumes the bench owns chip select and decides when the clock runs
`timescale 1ns/1ps
module acc_host_model #(
  parameter int HALF = 6
) (
  input wire logic    sys_clk,
  input wire logic    run,
  input wire logic    park_lvl,
  input wire logic    serial_data_out,
  input wire logic    serial_data_out_oe,
  output logic        serial_clk,
  output logic [23:0] rd_word,
  output int          rd_count,
  output int          rises
);
  int   nbit;
  logic armed;
  // clock is scaled far above the part's rate limit to keep the run short; its period never wanders
  initial
  begin
    {serial_clk, armed, rd_word} = '0;
    {rd_count, rises, nbit} = '0;
    forever
    begin
      @(negedge sys_clk);
      if (!run)
        serial_clk = park_lvl;
      else
      begin
        if (armed)
        begin
          // a released pin reads unknown, never a fake bit
          rd_word = {rd_word[22:0], serial_data_out_oe ? serial_data_out : 1'bx};
          nbit++;
        end
        serial_clk = 1'b1;
        rises++;
        if (nbit == 24)
        begin
          rd_count++;
          nbit = 0;
          armed = 1'b0;
        end
        repeat (HALF) @(negedge sys_clk);
        // the fall after the arming rise carries no new bit
        if (!armed && serial_data_out_oe && !serial_data_out)
          armed = 1'b1;
        serial_clk = 1'b0;
        repeat (HALF - 1) @(negedge sys_clk);
      end
    end
  end
endmodule : acc_host_model

// File: testbench/acc_top_chk.sv
// pin-level assertions for acc_top
// bound into acc_top; sees its ports only
`timescale 1ns/1ps
module acc_top_chk #(
  parameter bit INT_OSC      = 1'b0,
  parameter bit RES20        = 1'b1,
  parameter int SLEEP_CYCLES = acc_pkg::SLEEP_CYCLES
) (
  input wire logic        sys_clk,
  input wire logic        nrst,
  input wire logic        serial_clk,
  input wire logic        chip_select_n,
  input wire logic [19:0] sample_data,
  input wire logic        over_range,
  input wire logic        osc_detect,
  input wire logic        serial_data_out,
  input wire logic        serial_data_out_oe,
  input wire logic        sleep_active,
  input wire logic        word_ready
);
  // ========================================
  // helper counters, raw pins
  logic [15:0] hi_ff, lo_ff, rise_ff;
  logic [3:0]  quiet_ff, up_ff;
  logic        sck_ff, cs_ff;
  always_ff @(posedge sys_clk or negedge nrst)
    if (!nrst)
    begin
      {hi_ff, lo_ff, rise_ff, quiet_ff, up_ff} <= '0;
      {sck_ff, cs_ff} <= 2'h0;
    end
    else
    begin
      sck_ff <= serial_clk;
      cs_ff <= chip_select_n;
      hi_ff <= serial_clk ? hi_ff + 16'(hi_ff != 16'hFFFF) : 16'h0;
      lo_ff <= !serial_clk ? lo_ff + 16'(lo_ff != 16'hFFFF) : 16'h0;
      // word count restarts in sleep, as the converter's does
      rise_ff <= sleep_active ? 16'h0 : rise_ff + 16'(serial_clk & ~sck_ff);
      quiet_ff <= (serial_clk != sck_ff || chip_select_n != cs_ff) ? 4'h0 : quiet_ff + 4'(quiet_ff != 4'hF);
      up_ff <= up_ff + 4'(up_ff != 4'hF);
    end
  // ========================================
  // properties
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence cs_off_s;
    chip_select_n [*4];
  endsequence
  sequence cs_on_s;
    (up_ff == 4'hF && !sleep_active) ##0 !chip_select_n [*6];
  endsequence
  chk_oe_release: assert property (cs_off_s |-> !serial_data_out_oe) else $error("oe while deselected");
  chk_oe_drive: assert property (cs_on_s |-> serial_data_out_oe) else $error("oe missing");
  chk_sleep_late: assert property (hi_ff == 16'(SLEEP_CYCLES + 6) |-> sleep_active) else $error("no sleep");
  chk_sleep_early: assert property ($rose(sleep_active) |-> hi_ff >= 16'(SLEEP_CYCLES))
    else $error("early sleep");
  chk_wake_late: assert property (lo_ff == 16'(acc_pkg::WAKE_CYCLES + 6) |-> !sleep_active)
    else $error("no wake");
  chk_wake_early: assert property ($fell(sleep_active) |-> lo_ff >= 16'(acc_pkg::WAKE_CYCLES))
    else $error("early wake");
  // serial clock rises only time conversions when the converter runs from the pin
  chk_word_rate: assert property (!INT_OSC && $rose(word_ready) |->
    rise_ff % 16'(acc_pkg::WORD_DIV) == 0 && rise_ff >= 16'((acc_pkg::SETTLE_WORDS + 1) * acc_pkg::WORD_DIV))
    else $error("word rate");
  // word arrival and sleep entry may move the data pin with no pin edge nearby
  chk_sdo_quiet: assert property (!INT_OSC && !sleep_active && $changed(serial_data_out)
    |-> quiet_ff <= 4'h6) else $error("stray bit");
endmodule : acc_top_chk

bind acc_top acc_top_chk #(.INT_OSC(INT_OSC), .RES20(RES20), .SLEEP_CYCLES(SLEEP_CYCLES)) i_chk (
  .sys_clk(sys_clk), .nrst(nrst), .serial_clk(serial_clk), .chip_select_n(chip_select_n),
  .sample_data(sample_data), .over_range(over_range), .osc_detect(osc_detect),
  .serial_data_out(serial_data_out), .serial_data_out_oe(serial_data_out_oe),
  .sleep_active(sleep_active), .word_ready(word_ready));

// File: testbench/testbench.sv
// self-checking bench for acc_top, external clock variant
// pins change at falling edges; the host model makes the serial clock
`timescale 1ns/1ps
module testbench;
  localparam int WD = acc_pkg::WORD_DIV;
  localparam int SLP = 200;
  logic        sys_clk, nrst, chip_select_n, over_range, osc_detect, run, park_lvl;
  logic [19:0] sample_data;
  logic        serial_clk, serial_data_out, serial_data_out_oe, sleep_active, word_ready;
  logic [23:0] rd_word;
  logic [23:0] exp_q[$];
  logic        serial_clk_16, sdo_16, oe_16;
  logic [23:0] rd_word_16;
  int          rd_count, rises, base, mismatches, checked, cycles, rd_count_16;

  acc_top #(.INT_OSC(1'b0), .RES20(1'b1), .SLEEP_CYCLES(SLP)) i_dut (
    .sys_clk(sys_clk), .nrst(nrst), .serial_clk(serial_clk), .chip_select_n(chip_select_n),
    .sample_data(sample_data), .over_range(over_range), .osc_detect(osc_detect),
    .serial_data_out(serial_data_out), .serial_data_out_oe(serial_data_out_oe),
    .sleep_active(sleep_active), .word_ready(word_ready));
  acc_host_model #(.HALF(6)) i_host (
    .sys_clk(sys_clk), .run(run), .park_lvl(park_lvl), .serial_data_out(serial_data_out),
    .serial_data_out_oe(serial_data_out_oe), .serial_clk(serial_clk), .rd_word(rd_word),
    .rd_count(rd_count), .rises(rises));
  // second converter with the 16-bit word layout, read by an identical host in lock step
  acc_top #(.INT_OSC(1'b0), .RES20(1'b0), .SLEEP_CYCLES(SLP)) i_dut_16 (
    .sys_clk(sys_clk), .nrst(nrst), .serial_clk(serial_clk_16), .chip_select_n(chip_select_n),
    .sample_data(sample_data), .over_range(over_range), .osc_detect(osc_detect),
    .serial_data_out(sdo_16), .serial_data_out_oe(oe_16), .sleep_active(), .word_ready());
  acc_host_model #(.HALF(6)) i_host_16 (
    .sys_clk(sys_clk), .run(run), .park_lvl(park_lvl), .serial_data_out(sdo_16),
    .serial_data_out_oe(oe_16), .serial_clk(serial_clk_16), .rd_word(rd_word_16),
    .rd_count(rd_count_16), .rises());

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ========================================
  // shared tasks
  task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic new_values();
    sample_data = 20'($urandom);
    over_range = 1'($urandom);
    osc_detect = 1'($urandom);
    exp_q.push_back({1'b0, over_range, osc_detect, 1'b0, sample_data});
  endtask : new_values

  task automatic read_word(input int n);
    int          c0;
    int          c1;
    logic [23:0] exp;
    c0 = rd_count;
    c1 = rd_count_16;
    while (word_ready !== 1'b1) @(negedge sys_clk);
    check(24'(rises - base), 24'(n * WD), "rises");
    base = rises;
    while (rd_count == c0 || rd_count_16 == c1) @(negedge sys_clk);
    exp = exp_q.pop_front();
    check(rd_word, exp, "word");
    check(rd_word_16, {exp[23:20], 4'h0, exp[15:0]}, "word 16");
    // the flag drops a few clocks after the last rise; waiting keeps the next call from seeing it
    repeat (4) @(negedge sys_clk);
    check(24'(word_ready), 24'h0, "ready clear");
    new_values();
  endtask : read_word

  task automatic report_and_stop();
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  // watchdog sized for two settle periods, three read words and the sleep cycle
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 95000)
    begin
      mismatches++;
      $display("ERROR %0t timeout", $time);
      report_and_stop();
    end
  end

  // ========================================
  // main sequence
  initial
  begin
    void'($urandom(32'hB735CB37));
    {nrst, run, park_lvl, over_range, osc_detect} = '0;
    chip_select_n = 1'b1;
    sample_data = '0;
    {mismatches, checked, cycles, base} = '0;
    repeat (8) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (4) @(negedge sys_clk);
    chip_select_n = 1'b0;
    new_values();
    run = 1'b1;
    read_word(acc_pkg::SETTLE_WORDS + 1);
    read_word(1);
    chip_select_n = 1'b1;
    repeat (5) @(negedge sys_clk);
    check(24'(serial_data_out_oe), 24'h0, "oe");
    park_lvl = 1'b1;
    run = 1'b0;
    repeat (SLP + 30) @(negedge sys_clk);
    check(24'(sleep_active), 24'h1, "sleep");
    park_lvl = 1'b0;
    repeat (980) @(negedge sys_clk);
    check(24'(sleep_active), 24'h1, "wake early");
    repeat (40) @(negedge sys_clk);
    check(24'(sleep_active), 24'h0, "wake");
    chip_select_n = 1'b0;
    base = rises;
    run = 1'b1;
    repeat (5) @(negedge sys_clk);
    check(24'(serial_data_out_oe), 24'h1, "oe on");
    read_word(acc_pkg::SETTLE_WORDS + 1);
    report_and_stop();
  end
endmodule : testbench
